// ---- hdl/csr_core_regs.sv ----
// dedicated cpu register set with psw, flag logic and bank addressing
// assumes one ahb-lite master with hready tied to our hreadyout
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module csr_core_regs
   import csr_pkg::*;
#(
   parameter logic [15:0] IO_TOP = CSR_IO_TOP,
   parameter logic [15:0] PROG_BASE = CSR_PROG_BASE,
   parameter logic [15:0] VEC_BASE = CSR_VEC_BASE
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [15:0] GP_ADDR,
   output logic IRQ_TAKE,
   output logic [1:0] MEM_AREA
);
   // bus address phase capture
   csr_acc_t acc_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_q <= '0;
      end else if (HREADY) begin
         acc_q.addr <= HADDR[7:0];
         acc_q.write <= HSEL && HTRANS == CSR_HTRANS_NONSEQ && HWRITE && HSIZE == CSR_HSIZE_WORD;
         acc_q.read <= HSEL && HTRANS == CSR_HTRANS_NONSEQ && !HWRITE;
      end else begin
         acc_q <= acc_q;
      end
   end

   logic [15:0] ip_q, acc16_q, tacc_q, idx_q, exp_q, stk_q, psw_q;
   logic [2:0] op_q;
   logic [1:0] req_lvl_q;
   logic req_q;
   csr_alu_t alu;
   logic [8:0] s8;
   logic [4:0] s4;
   logic [16:0] s16;
   logic wr_ip, wr_acc, wr_tacc, wr_idx, wr_exp, wr_stk, wr_psw, wr_op, wr_irq, op_go;

   always_comb begin
      wr_ip = acc_q.write && acc_q.addr == CSR_OFF_IP;
      wr_acc = acc_q.write && acc_q.addr == CSR_OFF_ACC;
      wr_tacc = acc_q.write && acc_q.addr == CSR_OFF_TACC;
      wr_idx = acc_q.write && acc_q.addr == CSR_OFF_IDX;
      wr_exp = acc_q.write && acc_q.addr == CSR_OFF_EXP;
      wr_stk = acc_q.write && acc_q.addr == CSR_OFF_STK;
      wr_psw = acc_q.write && acc_q.addr == CSR_OFF_PSW;
      wr_op = acc_q.write && acc_q.addr == CSR_OFF_OP;
      wr_irq = acc_q.write && acc_q.addr == CSR_OFF_IRQ;
      // code 7 is undefined and must not wipe the accumulator
      op_go = wr_op && HWDATA[2:0] != 3'(CSR_OP_NONE) && HWDATA[2:0] <= 3'(CSR_OP_SHR8);
   end

   // flag unit, byte ops use low bytes only
   always_comb begin
      alu = '0;
      s8 = '0;
      s4 = '0;
      s16 = '0;
      case (csr_op_t'(HWDATA[2:0]))
         CSR_OP_ADD8: begin
            s8 = {1'b0, acc16_q[7:0]} + {1'b0, tacc_q[7:0]};
            s4 = {1'b0, acc16_q[3:0]} + {1'b0, tacc_q[3:0]};
         end
         CSR_OP_SUB8: begin
            s8 = {1'b0, acc16_q[7:0]} - {1'b0, tacc_q[7:0]};
            s4 = {1'b0, acc16_q[3:0]} - {1'b0, tacc_q[3:0]};
         end
         CSR_OP_ADD16: s16 = {1'b0, acc16_q} + {1'b0, tacc_q};
         CSR_OP_SUB16: s16 = {1'b0, acc16_q} - {1'b0, tacc_q};
         default: s8 = '0;
      endcase
      case (csr_op_t'(HWDATA[2:0]))
         CSR_OP_ADD8, CSR_OP_SUB8: begin
            alu.res = {acc16_q[15:8], s8[7:0]};
            alu.h = s4[4];
            alu.c = s8[8];
            alu.n = s8[7];
            alu.z = s8[7:0] == 8'h00;
            if (csr_op_t'(HWDATA[2:0]) == CSR_OP_ADD8) begin
               alu.v = acc16_q[7] == tacc_q[7] && s8[7] != acc16_q[7];
            end else begin
               alu.v = acc16_q[7] != tacc_q[7] && s8[7] != acc16_q[7];
            end
         end
         CSR_OP_ADD16, CSR_OP_SUB16: begin
            alu.res = s16[15:0];
            alu.h = psw_q[CSR_CC_H];
            alu.c = s16[16];
            alu.n = s16[15];
            alu.z = s16[15:0] == 16'h0000;
            if (csr_op_t'(HWDATA[2:0]) == CSR_OP_ADD16) begin
               alu.v = acc16_q[15] == tacc_q[15] && s16[15] != acc16_q[15];
            end else begin
               alu.v = acc16_q[15] != tacc_q[15] && s16[15] != acc16_q[15];
            end
         end
         CSR_OP_SHL8, CSR_OP_SHR8: begin
            if (csr_op_t'(HWDATA[2:0]) == CSR_OP_SHL8) begin
               alu.res = {acc16_q[15:8], acc16_q[6:0], 1'b0};
               alu.c = acc16_q[7];
            end else begin
               alu.res = {acc16_q[15:8], 1'b0, acc16_q[7:1]};
               alu.c = acc16_q[0];
            end
            alu.h = psw_q[CSR_CC_H];
            alu.n = alu.res[7];
            alu.z = alu.res[7:0] == 8'h00;
            alu.v = psw_q[CSR_CC_V];
         end
         default: alu = '0;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ip_q <= CSR_RST_WORD;
      end else if (wr_ip) begin
         ip_q <= HWDATA[15:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         acc16_q <= CSR_RST_WORD;
      end else if (op_go) begin
         acc16_q <= alu.res;
      end else if (wr_acc) begin
         acc16_q <= HWDATA[15:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tacc_q <= CSR_RST_WORD;
      end else if (wr_tacc) begin
         tacc_q <= HWDATA[15:0];
      end
   end

   // address registers
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         idx_q <= CSR_RST_WORD;
         exp_q <= CSR_RST_WORD;
         stk_q <= CSR_RST_SP;
      end else begin
         if (wr_idx) begin
            idx_q <= HWDATA[15:0];
         end
         if (wr_exp) begin
            exp_q <= HWDATA[15:0];
         end
         if (wr_stk) begin
            stk_q <= HWDATA[15:0];
         end
      end
   end

   // status word; an operation overrides a plain write entirely and sets only the flags
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         psw_q <= CSR_RST_PSW;
      end else if (op_go) begin
         psw_q[CSR_CC_H] <= alu.h;
         psw_q[CSR_CC_N] <= alu.n;
         psw_q[CSR_CC_Z] <= alu.z;
         psw_q[CSR_CC_V] <= alu.v;
         psw_q[CSR_CC_C] <= alu.c;
      end else if (wr_psw) begin
         psw_q <= HWDATA[15:0];
      end
   end

   // opcode register bits 10:8 kept for bank addressing
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         op_q <= '0;
      end else if (wr_op) begin
         op_q <= HWDATA[10:8];
      end
   end

   // bank pointer sampled now, not at decode, so late psw writes count
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         GP_ADDR <= {CSR_GP_HI, 8'h00};
      end else begin
         GP_ADDR <= {CSR_GP_HI, psw_q[CSR_BP_LSB +: CSR_BP_W], op_q};
      end
   end

   // interrupt request input register; level 3 never beats anything
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         req_q <= 1'b0;
         req_lvl_q <= '0;
      end else if (wr_irq) begin
         req_q <= HWDATA[2];
         req_lvl_q <= HWDATA[1:0];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         IRQ_TAKE <= 1'b0;
      end else begin
         IRQ_TAKE <= req_q && psw_q[CSR_CC_IE]
            && req_lvl_q < psw_q[CSR_CC_IL1:CSR_CC_IL0];
      end
   end

   // area of the current instruction pointer
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         MEM_AREA <= 2'(CSR_AREA_IO);
      end else if (ip_q >= VEC_BASE) begin
         MEM_AREA <= 2'(CSR_AREA_VEC);
      end else if (ip_q >= PROG_BASE) begin
         MEM_AREA <= 2'(CSR_AREA_PROG);
      end else if (ip_q > IO_TOP) begin
         MEM_AREA <= 2'(CSR_AREA_DATA);
      end else begin
         MEM_AREA <= 2'(CSR_AREA_IO);
      end
   end

   // read mux, registered in the data phase edge
   logic [31:0] rd;
   always_comb begin
      if (HADDR[7:0] == CSR_OFF_IP) begin
         rd = {16'h0000, ip_q};
      end else if (HADDR[7:0] == CSR_OFF_ACC) begin
         rd = {16'h0000, acc16_q};
      end else if (HADDR[7:0] == CSR_OFF_TACC) begin
         rd = {16'h0000, tacc_q};
      end else if (HADDR[7:0] == CSR_OFF_IDX) begin
         rd = {16'h0000, idx_q};
      end else if (HADDR[7:0] == CSR_OFF_EXP) begin
         rd = {16'h0000, exp_q};
      end else if (HADDR[7:0] == CSR_OFF_STK) begin
         rd = {16'h0000, stk_q};
      end else if (HADDR[7:0] == CSR_OFF_PSW) begin
         rd = {16'h0000, psw_q};
      end else if (HADDR[7:0] == CSR_OFF_GPA) begin
         rd = {16'h0000, GP_ADDR};
      end else if (HADDR[7:0] == CSR_OFF_IRQ) begin
         rd = {28'h000_0000, IRQ_TAKE, req_q, req_lvl_q};
      end else if (HADDR[7:0] == CSR_OFF_MAP) begin
         rd = {30'h0000_0000, MEM_AREA};
      end else begin
         rd = 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HRDATA <= 32'h0000_0000;
      end else if (HREADY && HSEL && HTRANS == CSR_HTRANS_NONSEQ && !HWRITE) begin
         HRDATA <= rd;
      end
   end

   // zero wait state, always okay
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   a_gp_addr_form: assert property (@(posedge CLK) disable iff (!RESETN)
      GP_ADDR[15:8] == CSR_GP_HI && GP_ADDR[7:3] == $past(psw_q[CSR_BP_LSB +: CSR_BP_W]))
      else $error("register bank address malformed");
   a_irq_gate_ie: assert property (@(posedge CLK) disable iff (!RESETN)
      !psw_q[CSR_CC_IE] |=> !IRQ_TAKE)
      else $error("interrupt taken while disabled");
   a_irq_level_low: assert property (@(posedge CLK) disable iff (!RESETN)
      req_lvl_q == 2'b11 |=> !IRQ_TAKE)
      else $error("lowest level interrupt was taken");
   a_zero_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go |=> psw_q[CSR_CC_Z] == (acc16_q[7:0] == 8'h00) || acc16_q[15:8] != $past(acc16_q[15:8])
      || $past(HWDATA[2:0]) inside {3'(CSR_OP_ADD16), 3'(CSR_OP_SUB16)})
      else $error("zero flag wrong after operation");
   a_neg_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go && HWDATA[2:0] == 3'(CSR_OP_ADD8) |=> psw_q[CSR_CC_N] == acc16_q[7])
      else $error("negative flag wrong after add");
   a_carry_shift: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go && HWDATA[2:0] == 3'(CSR_OP_SHL8) |=> psw_q[CSR_CC_C] == $past(acc16_q[7]))
      else $error("carry not shifted-out bit");
   a_half_carry: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go && HWDATA[2:0] == 3'(CSR_OP_ADD8) |=>
      psw_q[CSR_CC_H] == (($past(acc16_q[3:0]) + $past(tacc_q[3:0])) > 5'(15)))
      else $error("half carry wrong");
   a_acc_high_kept: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go && HWDATA[2:0] == 3'(CSR_OP_SUB8) |=> $stable(acc16_q[15:8]))
      else $error("byte operation touched high byte");
   a_ovf_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go && HWDATA[2:0] == 3'(CSR_OP_ADD8) && acc16_q[7] && tacc_q[7] && !acc16_q[6] && !tacc_q[6]
      |=> psw_q[CSR_CC_V])
      else $error("overflow not flagged");
   a_vec_area: assert property (@(posedge CLK) disable iff (!RESETN)
      ip_q >= VEC_BASE |=> MEM_AREA == 2'(CSR_AREA_VEC))
      else $error("vector area not reported");
   a_ip_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_ip |=> ip_q == $past(HWDATA[15:0]))
      else $error("instruction pointer not loaded");
   a_acc_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_acc |=> acc16_q == $past(HWDATA[15:0]))
      else $error("accumulator not loaded");
   a_tacc_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_tacc |=> tacc_q == $past(HWDATA[15:0]))
      else $error("second accumulator not loaded");
   a_idx_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_idx |=> idx_q == $past(HWDATA[15:0]))
      else $error("index pointer not loaded");
   a_exp_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_exp |=> exp_q == $past(HWDATA[15:0]))
      else $error("extra pointer not loaded");
   a_stk_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_stk |=> stk_q == $past(HWDATA[15:0]))
      else $error("stack pointer not loaded");
   a_psw_load: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_psw |=> psw_q == $past(HWDATA[15:0]))
      else $error("status word not loaded");
   a_carry_add: assert property (@(posedge CLK) disable iff (!RESETN)
      op_go && HWDATA[2:0] == 3'(CSR_OP_ADD8) |=>
      psw_q[CSR_CC_C] == (({1'b0, $past(acc16_q[7:0])} + {1'b0, $past(tacc_q[7:0])}) > 9'h0FF))
      else $error("carry wrong after add");
   a_irq_taken: assert property (@(posedge CLK) disable iff (!RESETN)
      req_q && psw_q[CSR_CC_IE] && req_lvl_q == 2'b00 && psw_q[CSR_CC_IL1:CSR_CC_IL0] != 2'b00 |=> IRQ_TAKE)
      else $error("top level interrupt not taken");
   a_data_area: assert property (@(posedge CLK) disable iff (!RESETN)
      ip_q > IO_TOP && ip_q < PROG_BASE |=> MEM_AREA == 2'(CSR_AREA_DATA))
      else $error("data area not reported");
   a_io_area: assert property (@(posedge CLK) disable iff (!RESETN)
      ip_q <= IO_TOP |=> MEM_AREA == 2'(CSR_AREA_IO))
      else $error("io area not reported");
   a_gp_opcode: assert property (@(posedge CLK) disable iff (!RESETN)
      GP_ADDR[2:0] == $past(op_q))
      else $error("register address opcode bits wrong");
endmodule : csr_core_regs

// ---- hdl/csr_pkg.sv ----
// package for the cpu dedicated register set block
// assumes a 32-bit ahb-lite bus and one 20 MHz clock
package csr_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] CSR_OFF_IP = 8'h00;
   localparam logic [7:0] CSR_OFF_ACC = 8'h04;
   localparam logic [7:0] CSR_OFF_TACC = 8'h08;
   localparam logic [7:0] CSR_OFF_IDX = 8'h0C;
   localparam logic [7:0] CSR_OFF_EXP = 8'h10;
   localparam logic [7:0] CSR_OFF_STK = 8'h14;
   localparam logic [7:0] CSR_OFF_PSW = 8'h18;
   localparam logic [7:0] CSR_OFF_OP = 8'h1C;
   localparam logic [7:0] CSR_OFF_RES = 8'h20;
   localparam logic [7:0] CSR_OFF_GPA = 8'h24;
   localparam logic [7:0] CSR_OFF_IRQ = 8'h28;
   localparam logic [7:0] CSR_OFF_MAP = 8'h2C;
   // reset values
   localparam logic [15:0] CSR_RST_WORD = 16'h0000;
   localparam logic [15:0] CSR_RST_SP = 16'h0000;
   localparam logic [15:0] CSR_RST_PSW = 16'h0030;
   // condition code bit positions
   localparam int CSR_CC_C = 0;
   localparam int CSR_CC_V = 1;
   localparam int CSR_CC_Z = 2;
   localparam int CSR_CC_N = 3;
   localparam int CSR_CC_IL0 = 4;
   localparam int CSR_CC_IL1 = 5;
   localparam int CSR_CC_IE = 6;
   localparam int CSR_CC_H = 7;
   // bank pointer field inside the psw upper byte
   localparam int CSR_BP_LSB = 11;
   localparam int CSR_BP_W = 5;
   localparam logic [7:0] CSR_GP_HI = 8'h01;
   localparam logic [4:0] CSR_BANK_LIMIT = 5'h10;
   // memory map defaults
   localparam logic [15:0] CSR_IO_TOP = 16'h007F;
   localparam logic [15:0] CSR_PROG_BASE = 16'h8000;
   localparam logic [15:0] CSR_VEC_BASE = 16'hFFC0;
   // ahb constants
   localparam logic [1:0] CSR_HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] CSR_HSIZE_WORD = 3'b010;
   // operation codes
   typedef enum logic [2:0] {
      CSR_OP_NONE,
      CSR_OP_ADD8,
      CSR_OP_SUB8,
      CSR_OP_ADD16,
      CSR_OP_SUB16,
      CSR_OP_SHL8,
      CSR_OP_SHR8
   } csr_op_t;
   typedef struct packed {
      logic [15:0] res;
      logic h;
      logic n;
      logic z;
      logic v;
      logic c;
   } csr_alu_t;
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic read;
   } csr_acc_t;
   typedef enum logic [1:0] {
      CSR_AREA_IO,
      CSR_AREA_DATA,
      CSR_AREA_PROG,
      CSR_AREA_VEC
   } csr_area_t;
endpackage : csr_pkg

// ---- testbench/tb.sv ----
// self-checking bench for the cpu dedicated register set
// assumes csr_pkg and csr_core_regs compiled first; the bench is the only ahb-lite master
`timescale 1ns/1ps
module tb
   import csr_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [15:0] gp_addr;
   logic irq_take;
   logic [1:0] mem_area;
   int errors = 0;
   int checks_done = 0;
   logic [2:0] bus_size = CSR_HSIZE_WORD;

   always #25 clk = ~clk;

   // single slave, so its hreadyout is the bus hready
   csr_core_regs csr_core_regs_i (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .GP_ADDR(gp_addr), .IRQ_TAKE(irq_take), .MEM_AREA(mem_area));

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // bounded wait; a hung slave ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (hreadyout !== 1'b1) begin
         errors++;
         $display("unexpected hready expected 1 seen %b", hreadyout);
         complete_run();
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= CSR_HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= bus_size;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      chk(name, exp, x & m);
   endtask : rdc

   task automatic test_reset();
      chk("gp_addr pin", 32'h0000_0100, {16'h0000, gp_addr});
      chk("irq_take pin", 32'h0000_0000, {31'h0000_0000, irq_take});
      chk("mem_area pin", 32'h0000_0000, {30'h0000_0000, mem_area});
      rdc("ip", CSR_OFF_IP, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc("acc", CSR_OFF_ACC, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc("psw", CSR_OFF_PSW, 32'hFFFF_FFFF, 32'h0000_0030);
   endtask : test_reset

   // each register keeps 16 bits only; upper half of the word must read zero
   task automatic test_regs();
      logic [7:0] offs [6] = '{CSR_OFF_IP, CSR_OFF_ACC, CSR_OFF_TACC, CSR_OFF_IDX, CSR_OFF_EXP, CSR_OFF_STK};
      for (int i = 0; i < 6; i++) begin
         wr(offs[i], {16'hA5A5, 16'h1234 + 16'(i)});
      end
      for (int i = 0; i < 6; i++) begin
         rdc("reg", offs[i], 32'hFFFF_FFFF, {16'h0000, 16'h1234 + 16'(i)});
      end
      wr(CSR_OFF_PSW, 32'h0000_A8C5);
      rdc("psw", CSR_OFF_PSW, 32'hFFFF_FFFF, 32'h0000_A8C5);
   endtask : test_regs

   // psw written right before the opcode: the bank in force then must be used
   task automatic test_bank();
      logic [4:0] banks [4] = '{5'h00, 5'h05, 5'h0F, 5'h0A};
      logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h0, 3'h5};
      for (int i = 0; i < 4; i++) begin
         wr(CSR_OFF_PSW, {16'h0000, banks[i], 11'h000});
         wr(CSR_OFF_OP, {21'h00_0000, codes[i], 8'h00});
         repeat (2) @(posedge clk);
         rdc("gp reg", CSR_OFF_GPA, 32'h0000_FFFF, {16'h0000, 8'h01, banks[i], codes[i]});
         chk("gp pin", {16'h0000, 8'h01, banks[i], codes[i]}, {16'h0000, gp_addr});
      end
   endtask : test_bank

   // flags byte: h n z v c at bits 7 3 2 1 0; psw cleared first so untouched flags read 0
   task automatic test_alu();
      csr_op_t ops [10] = '{CSR_OP_ADD8, CSR_OP_ADD8, CSR_OP_ADD8, CSR_OP_SUB8, CSR_OP_SUB8, CSR_OP_SUB8,
         CSR_OP_SHL8, CSR_OP_SHR8, CSR_OP_ADD16, CSR_OP_SUB16};
      logic [15:0] av [10] = '{16'h000F, 16'h0080, 16'h007F, 16'h0010, 16'h0000, 16'h0080, 16'h0081, 16'h0001,
         16'h7FFF, 16'h0000};
      logic [15:0] tv [10] = '{16'h0001, 16'h0080, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
         16'h0001, 16'h0001};
      logic [15:0] res [10] = '{16'h0010, 16'h0000, 16'h0080, 16'h000F, 16'h00FF, 16'h007F, 16'h0002, 16'h0000,
         16'h8000, 16'hFFFF};
      logic [7:0] fl [10] = '{8'h80, 8'h07, 8'h8A, 8'h80, 8'h89, 8'h82, 8'h01, 8'h05, 8'h0A, 8'h09};
      logic [31:0] rm;
      logic [31:0] fm;
      for (int i = 0; i < 10; i++) begin
         rm = (i >= 8) ? 32'h0000_FFFF : 32'h0000_00FF;
         fm = (i >= 8) ? 32'h0000_008F : 32'h0000_00FF;
         wr(CSR_OFF_PSW, 32'h0000_0000);
         wr(CSR_OFF_ACC, {16'h0000, av[i]});
         wr(CSR_OFF_TACC, {16'h0000, tv[i]});
         wr(CSR_OFF_OP, {29'h0000_0000, ops[i]});
         repeat (2) @(posedge clk);
         rdc("acc result", CSR_OFF_ACC, rm, {16'h0000, res[i]} & rm);
         rdc("flags", CSR_OFF_PSW, fm, {24'h00_0000, fl[i]} & fm);
      end
   endtask : test_alu

   task automatic test_irq();
      logic [15:0] psw [7] = '{16'h0030, 16'h0070, 16'h0070, 16'h0060, 16'h0060, 16'h0040, 16'h0070};
      logic [2:0] req [7] = '{3'h4, 3'h4, 3'h7, 3'h5, 3'h6, 3'h4, 3'h3};
      logic take [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < 7; i++) begin
         wr(CSR_OFF_PSW, {16'h0000, psw[i]});
         wr(CSR_OFF_IRQ, {29'h0000_0000, req[i]});
         repeat (2) @(posedge clk);
         chk("irq pin", {31'h0000_0000, take[i]}, {31'h0000_0000, irq_take});
         rdc("irq reg", CSR_OFF_IRQ, 32'h0000_0008, {28'h000_0000, take[i], 3'h0});
      end
   endtask : test_irq

   // area bounds: io up to 007f, program from 8000, vectors from ffc0
   task automatic test_map();
      logic [15:0] ip [8] = '{16'h0000, 16'h007F, 16'h0080, 16'h7FFF, 16'h8000, 16'hFFBF, 16'hFFC0, 16'hFFFF};
      logic [1:0] area [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
      for (int i = 0; i < 8; i++) begin
         wr(CSR_OFF_IP, {16'h0000, ip[i]});
         repeat (2) @(posedge clk);
         chk("area pin", {30'h0000_0000, area[i]}, {30'h0000_0000, mem_area});
         rdc("area reg", CSR_OFF_MAP, 32'h0000_0003, {30'h0000_0000, area[i]});
      end
   endtask : test_map

   task automatic test_unmapped();
      wr(CSR_OFF_RES, 32'hFFFF_FFFF);
      rdc("reserved", CSR_OFF_RES, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
      chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
      wr(CSR_OFF_ACC, 32'h0000_5A5A);
      wr(CSR_OFF_OP, 32'h0000_0007);
      rdc("acc after code 7", CSR_OFF_ACC, 32'hFFFF_FFFF, 32'h0000_5A5A);
      // halfword writes are refused
      bus_size = 3'h1;
      wr(CSR_OFF_ACC, 32'h0000_1111);
      bus_size = CSR_HSIZE_WORD;
      rdc("acc after halfword write", CSR_OFF_ACC, 32'hFFFF_FFFF, 32'h0000_5A5A);
   endtask : test_unmapped

   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      test_reset();
      test_regs();
      test_bank();
      test_alu();
      test_irq();
      test_map();
      test_unmapped();
      complete_run();
   end
endmodule : tb
